// [bench/status_flags_and_data_addressing_tb.sv]
// self-checking bench for the condition flags and data addressing core
`timescale 1ns/100ps
module status_flags_and_data_addressing_tb;
  import core_addr_pkg::*;

  // ==========================================================
  // design signals
  logic        core_clk;
  logic        nrst;
  logic        op_valid;
  op_kind_e    op_kind;
  logic [7:0]  file_addr;
  logic        access_sel;
  logic        dest_sel;
  logic [2:0]  bit_sel;
  logic [7:0]  literal;
  logic [11:0] long_src;
  logic [11:0] long_dst;
  logic [19:0] jump_addr;
  logic [3:0]  bank_select_reg;
  logic [7:0]  wreg;
  logic        extended_isa_enable;
  logic [7:0]  file_rdata;
  logic [11:0] mem_rd_addr;
  logic        mem_wr_en;
  logic [11:0] mem_wr_addr;
  logic [7:0]  mem_wr_data;
  logic        wreg_wr_en;
  logic [7:0]  wreg_wr_data;
  logic        jump_en;
  logic [19:0] jump_target;
  logic [7:0]  alu_condition_flags;
  logic [11:0] pointer_pair_0;
  logic [11:0] pointer_pair_1;
  logic [11:0] pointer_pair_2;

  typedef struct {
    op_kind_e    op;
    logic [7:0]  f;
    logic        a;
    logic        d;
    logic [7:0]  x;
    logic [7:0]  w;
    logic [3:0]  bank;
    logic [11:0] addr;
  } row_s;

  row_s        rows [8];
  row_s        r;
  int          error_cnt;
  int          n_tests;
  int          cyc;
  logic [11:0] rd_seen;
  logic [12:0] ex;
  logic        is_sub;
  logic        is_lit;
  logic        to_mem;
  logic [7:0]  vf [5];
  logic [7:0]  vw [5];
  logic [11:0] va [5];
  logic [11:0] vp [5];

  core_status_addr i_dut (
    .core_clk(core_clk), .nrst(nrst), .op_valid(op_valid),
    .op_kind(op_kind), .file_addr(file_addr), .access_sel(access_sel),
    .dest_sel(dest_sel), .bit_sel(bit_sel), .literal(literal),
    .long_src(long_src), .long_dst(long_dst), .jump_addr(jump_addr),
    .bank_select_reg(bank_select_reg), .wreg(wreg),
    .extended_isa_enable(extended_isa_enable), .file_rdata(file_rdata),
    .mem_rd_addr(mem_rd_addr), .mem_wr_en(mem_wr_en),
    .mem_wr_addr(mem_wr_addr), .mem_wr_data(mem_wr_data),
    .wreg_wr_en(wreg_wr_en), .wreg_wr_data(wreg_wr_data),
    .jump_en(jump_en), .jump_target(jump_target),
    .alu_condition_flags(alu_condition_flags),
    .pointer_pair_0(pointer_pair_0), .pointer_pair_1(pointer_pair_1),
    .pointer_pair_2(pointer_pair_2)
  );

  // ==========================================================
  // clock, timeout and shared tasks
  always #20 core_clk = ~core_clk;

  // the whole run needs under ninety cycles
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 2000) begin
      error_cnt++;
      tally_and_finish();
    end
  end

  task automatic tally_and_finish();
    $display("compares %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic chk(input logic [19:0] seen, input logic [19:0] exp);
    n_tests++;
    if (seen !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic put(input op_kind_e o, input logic [7:0] f,
                     input logic a, input logic d, input logic [7:0] w);
    op_kind = o;
    file_addr = f;
    access_sel = a;
    dest_sel = d;
    wreg = w;
  endtask

  // one op per call; outputs of the op stand right after return
  task automatic fire();
    @(posedge core_clk);
    #1 op_valid = 1'b1;
    #2 rd_seen = mem_rd_addr;
    @(posedge core_clk);
    #1 op_valid = 1'b0;
  endtask

  // subtraction adds the complement plus one; flags {n,ov,z,dc,c}
  function automatic logic [12:0] arith(input logic [7:0] x, y,
                                         input logic sub);
    logic [7:0] y2;
    logic [8:0] s;
    logic [4:0] lo;
    y2 = sub ? ~y : y;
    s  = {1'b0, x} + {1'b0, y2} + {8'h00, sub};
    lo = {1'b0, x[3:0]} + {1'b0, y2[3:0]} + {4'h0, sub};
    return {s[7:0], s[7], (x[7] == y2[7]) && (s[7] != x[7]),
            s[7:0] == 8'h00, lo[4], s[8]};
  endfunction

  // ==========================================================
  // main sequence
  initial begin
    core_clk = 1'b0;
    nrst = 1'b0;
    op_valid = 1'b0;
    put(op_nop, 8'h00, 1'b0, 1'b0, 8'h00);
    {bit_sel, literal, long_src, long_dst, jump_addr} = '0;
    {bank_select_reg, extended_isa_enable, file_rdata} = '0;
    rows[0] = '{op_add_reg, 8'h10, 1'b0, 1'b1, 8'h7f, 8'h01, 4'h3, 12'h010};
    rows[1] = '{op_add_reg, 8'h10, 1'b1, 1'b0, 8'hff, 8'h01, 4'h3, 12'h310};
    rows[2] = '{op_sub_reg, 8'h90, 1'b0, 1'b1, 8'h05, 8'h05, 4'h2, 12'hf90};
    rows[3] = '{op_sub_reg, 8'h20, 1'b1, 1'b1, 8'h00, 8'h01, 4'hf, 12'hf20};
    rows[4] = '{op_add_lit, 8'h00, 1'b0, 1'b1, 8'h08, 8'h08, 4'h0, 12'h000};
    rows[5] = '{op_sub_lit, 8'h00, 1'b0, 1'b1, 8'h80, 8'h01, 4'h0, 12'h000};
    rows[6] = '{op_add_reg, 8'h7f, 1'b0, 1'b1, 8'h80, 8'h80, 4'h5, 12'h07f};
    rows[7] = '{op_add_reg, 8'h80, 1'b0, 1'b1, 8'h3c, 8'h44, 4'h5, 12'hf80};
    repeat (8) @(posedge core_clk);
    #1 nrst = 1'b1;
    chk(alu_condition_flags, 8'h00);
    chk(pointer_pair_0, 12'h000);
    $display("test reset done");

    foreach (rows[i]) begin
      r = rows[i];
      put(r.op, r.f, r.a, r.d, r.w);
      bank_select_reg = r.bank;
      literal = r.x;
      file_rdata = r.x;
      is_sub = (r.op == op_sub_reg) || (r.op == op_sub_lit);
      is_lit = (r.op == op_add_lit) || (r.op == op_sub_lit);
      to_mem = !is_lit && r.d;
      ex = arith(r.x, r.w, is_sub);
      fire();
      if (!is_lit) chk(rd_seen, r.addr);
      if (to_mem) chk(mem_wr_addr, r.addr);
      chk(mem_wr_en, to_mem);
      chk(wreg_wr_en, !to_mem);
      chk(to_mem ? mem_wr_data : wreg_wr_data, ex[12:5]);
      chk(alu_condition_flags, {3'h0, ex[4:0]});
      $display("test row %0d done", i);
    end

    // clearing the flag register only raises zero, nothing is written
    put(op_clr, 8'hd8, 1'b0, 1'b1, 8'h00);
    fire();
    chk(mem_wr_en, 1'b0);
    chk(alu_condition_flags, 8'h1e);
    put(op_move_w, 8'hd8, 1'b0, 1'b1, 8'hff);
    fire();
    chk(alu_condition_flags, 8'h1f);
    put(op_move_w, 8'hd8, 1'b0, 1'b1, 8'h00);
    fire();
    chk(alu_condition_flags, 8'h00);
    $display("test flag destination done");

    put(op_rot_left, 8'h30, 1'b0, 1'b0, 8'h00);
    file_rdata = 8'h88;
    fire();
    chk(wreg_wr_data, 8'h10);
    chk(alu_condition_flags, 8'h03);
    op_kind = op_rot_right;
    file_rdata = 8'h11;
    fire();
    chk(wreg_wr_data, 8'h88);
    chk(alu_condition_flags, 8'h13);
    $display("test rotate done");

    put(op_jump, 8'h00, 1'b0, 1'b0, 8'h00);
    jump_addr = 20'ha_5c3f;
    fire();
    chk(jump_en, 1'b1);
    chk(jump_target, 20'ha_5c3f);
    put(op_move_ff, 8'h00, 1'b1, 1'b0, 8'h00);
    {long_src, long_dst, bank_select_reg} = {12'h123, 12'h456, 4'h7};
    file_rdata = 8'h6b;
    fire();
    chk(rd_seen, 12'h123);
    chk(mem_wr_addr, 12'h456);
    chk(mem_wr_data, 8'h6b);
    $display("test jump and long move done");

    // upper nibble of the high byte is dropped; low byte wraps into high
    put(op_move_w, 8'he9, 1'b0, 1'b1, 8'hff);
    fire();
    put(op_move_w, 8'hea, 1'b0, 1'b1, 8'hf1);
    fire();
    chk(pointer_pair_0, 12'h1ff);
    vf = '{8'hee, 8'hed, 8'hec, 8'heb, 8'hef};
    vw = '{8'h5a, 8'h3c, 8'h11, 8'hfe, 8'h77};
    va = '{12'h1ff, 12'h200, 12'h200, 12'h1fe, 12'h200};
    vp = '{12'h200, 12'h1ff, 12'h200, 12'h200, 12'h200};
    bank_select_reg = 4'hf;
    for (int k = 0; k < 5; k++) begin
      put(op_move_w, vf[k], k == 4, 1'b1, vw[k]);
      fire();
      chk(mem_wr_en, 1'b1);
      chk(mem_wr_addr, va[k]);
      chk(mem_wr_data, vw[k]);
      chk(pointer_pair_0, vp[k]);
      chk(alu_condition_flags, 8'h13);
    end
    put(op_move_w, 8'he1, 1'b0, 1'b1, 8'h34);
    fire();
    chk(pointer_pair_1, 12'h034);
    put(op_move_w, 8'hda, 1'b0, 1'b1, 8'h03);
    fire();
    chk(pointer_pair_2, 12'h300);
    $display("test pointers done");

    // flag-neutral ops on the flag register store their result bits
    put(op_bit_clr, 8'hd8, 1'b0, 1'b1, 8'h00);
    bit_sel = 3'h4;
    fire();
    chk(alu_condition_flags, 8'h03);
    chk(mem_wr_en, 1'b0);
    op_kind = op_bit_set;
    bit_sel = 3'h3;
    fire();
    chk(alu_condition_flags, 8'h0b);
    op_kind = op_swap;
    fire();
    chk(alu_condition_flags, 8'h10);
    put(op_and, 8'h40, 1'b0, 1'b0, 8'h0f);
    file_rdata = 8'hf0;
    fire();
    chk(wreg_wr_data, 8'h00);
    chk(alu_condition_flags, 8'h04);
    op_kind = op_xor;
    fire();
    chk(wreg_wr_data, 8'hff);
    chk(alu_condition_flags, 8'h10);
    op_kind = op_or;
    file_rdata = 8'h00;
    wreg = 8'h00;
    fire();
    chk(alu_condition_flags, 8'h04);
    $display("test flag-neutral and logic ops done");

    // a pointer aimed at a virtual operand reads zero and writes no memory; a wreg destination is still written
    put(op_move_w, 8'he1, 1'b0, 1'b1, 8'he7);
    fire();
    put(op_move_w, 8'he2, 1'b0, 1'b1, 8'h0f);
    fire();
    chk(pointer_pair_1, 12'hfe7);
    put(op_move_w, 8'he7, 1'b0, 1'b1, 8'h55);
    fire();
    chk(mem_wr_en, 1'b0);
    put(op_add_reg, 8'he7, 1'b0, 1'b0, 8'h05);
    file_rdata = 8'h77;
    fire();
    chk(wreg_wr_data, 8'h05);
    chk(wreg_wr_en, 1'b1);
    $display("test pointer at virtual operand done");

    extended_isa_enable = 1'b1;
    put(op_add_reg, 8'h10, 1'b0, 1'b0, 8'h00);
    fire();
    chk(rd_seen, 12'h310);
    file_addr = 8'h60;
    fire();
    chk(rd_seen, 12'h060);
    extended_isa_enable = 1'b0;
    file_addr = 8'h10;
    fire();
    chk(rd_seen, 12'h010);
    $display("test indexed offset done");

    // second reset in mid-run clears pointers and flags again
    nrst = 1'b0;
    @(posedge core_clk);
    #1 nrst = 1'b1;
    chk(pointer_pair_2, 12'h000);
    chk(alu_condition_flags, 8'h00);
    $display("test second reset done");
    tally_and_finish();
  end

endmodule // status_flags_and_data_addressing_tb

// [hdl/alu_flag_unit.sv]
// combinational alu result and condition flag effects
`timescale 1ns/100ps
module alu_flag_unit
  import core_addr_pkg::*;
(
  input  wire core_addr_pkg::op_kind_e op,
  input  wire logic [7:0]              opnd_f,
  input  wire logic [7:0]              opnd_w,
  input  wire logic [7:0]              literal,
  input  wire logic [2:0]              bit_sel,
  input  wire logic                    carry_in,
  output logic      [7:0]              result,
  output logic      [4:0]              flag_mask,
  output logic      [4:0]              flag_val
);

  logic [7:0] a;
  logic [7:0] b;
  logic       sub;
  logic [8:0] sum;
  logic [4:0] nib;

  // subtraction adds the two's complement, so carry means no borrow
  always_comb begin
    sub = (op == op_sub_reg) || (op == op_sub_lit);
    a   = (op == op_add_lit || op == op_sub_lit) ? literal : opnd_f;
    b   = sub ? ~opnd_w : opnd_w;
    sum = {1'b0, a} + {1'b0, b} + {8'h00, sub};
    nib = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, sub};
  end

  always_comb begin
    result    = opnd_f;
    flag_mask = '0;
    flag_val  = '0;
    unique case (op)
      op_add_reg, op_add_lit, op_sub_reg, op_sub_lit: begin
        result               = sum[7:0];
        flag_mask            = 5'h1F;
        flag_val[FLAG_CARRY] = sum[8];
        flag_val[FLAG_NIB]   = nib[4];
        flag_val[FLAG_OVF]   = (a[7] == b[7]) && (sum[7] != a[7]);
      end
      op_and, op_or, op_xor: begin
        result    = (op == op_and) ? (opnd_f & opnd_w) :
                    (op == op_or)  ? (opnd_f | opnd_w) : (opnd_f ^ opnd_w);
        flag_mask = 5'h14;
      end
      op_clr: begin
        result    = 8'h00;
        flag_mask = 5'h04;
      end
      op_rot_left, op_rot_right: begin
        result    = (op == op_rot_left) ? {opnd_f[6:0], carry_in}
                                        : {carry_in, opnd_f[7:1]};
        flag_mask = 5'h17;
        flag_val[FLAG_CARRY] = (op == op_rot_left) ? opnd_f[7]
                                                   : opnd_f[0];
        flag_val[FLAG_NIB]   = (op == op_rot_left) ? opnd_f[3]
                                                   : opnd_f[4];
      end
      op_swap:    result = {opnd_f[3:0], opnd_f[7:4]};
      op_bit_set: result = opnd_f | (8'h01 << bit_sel);
      op_bit_clr: result = opnd_f & ~(8'h01 << bit_sel);
      op_move_w:  result = opnd_w;
      op_move_ff, op_jump, op_nop: result = opnd_f;
      default:    result = opnd_f;
    endcase
    flag_val[FLAG_NEG]  = result[7];
    flag_val[FLAG_ZERO] = (result == 8'h00);
  end

endmodule // alu_flag_unit

// [hdl/core_addr_pkg.sv]
// constants and types shared by the flag and data addressing logic
package core_addr_pkg;

  // ==========================================================
  // operation kinds presented by the instruction decoder
  typedef enum logic [4:0] {
    op_nop, op_add_reg, op_add_lit, op_sub_reg, op_sub_lit,
    op_and, op_or, op_xor, op_clr, op_rot_left, op_rot_right,
    op_swap, op_bit_set, op_bit_clr, op_move_w, op_move_ff, op_jump
  } op_kind_e;

  // ==========================================================
  // flag register layout
  localparam int          FLAG_NEG    = 4;
  localparam int          FLAG_OVF    = 3;
  localparam int          FLAG_ZERO   = 2;
  localparam int          FLAG_NIB    = 1;
  localparam int          FLAG_CARRY  = 0;
  localparam int          FLAG_W      = 5;
  localparam logic [4:0]  FLAGS_RESET = 5'h00;

  // ==========================================================
  // data memory map of the registers held in this block
  localparam logic [11:0] FLAGS_ADDR  = 12'h0FD8;
  localparam logic [11:0] VIRT_BASE [3] = '{12'h0FEF, 12'h0FE7, 12'h0FDF};
  localparam logic [11:0] PTR_LOW   [3] = '{12'h0FE9, 12'h0FE1, 12'h0FD9};
  localparam logic [11:0] PTR_HIGH  [3] = '{12'h0FEA, 12'h0FE2, 12'h0FDA};

  // distance below a pair's base selects the virtual operand kind
  localparam logic [2:0]  VIRT_PLAIN   = 3'h0;
  localparam logic [2:0]  VIRT_USE_INC = 3'h1;
  localparam logic [2:0]  VIRT_USE_DEC = 3'h2;
  localparam logic [2:0]  VIRT_INC_USE = 3'h3;
  localparam logic [2:0]  VIRT_ADD_W   = 3'h4;

  // ==========================================================
  // access bank split and indexed literal offset limit
  localparam logic [7:0]  ACCESS_SPLIT     = 8'h80;
  localparam logic [3:0]  ACCESS_HIGH_BANK = 4'hF;
  localparam logic [7:0]  INDEXED_LIMIT    = 8'h5F;
  localparam logic [11:0] PTR_RESET        = 12'h000;

endpackage

// [hdl/core_status_addr.sv]
// condition flags and data memory address generation of the core
`timescale 1ns/100ps
module core_status_addr
  import core_addr_pkg::*;
(
  input  wire logic                    core_clk,
  input  wire logic                    nrst,
  input  wire logic                    op_valid,
  input  wire core_addr_pkg::op_kind_e op_kind,
  input  wire logic [7:0]              file_addr,
  input  wire logic                    access_sel,
  input  wire logic                    dest_sel,
  input  wire logic [2:0]              bit_sel,
  input  wire logic [7:0]              literal,
  input  wire logic [11:0]             long_src,
  input  wire logic [11:0]             long_dst,
  input  wire logic [19:0]             jump_addr,
  input  wire logic [3:0]              bank_select_reg,
  input  wire logic [7:0]              wreg,
  input  wire logic                    extended_isa_enable,
  input  wire logic [7:0]              file_rdata,
  output logic      [11:0]             mem_rd_addr,
  output logic                         mem_wr_en,
  output logic      [11:0]             mem_wr_addr,
  output logic      [7:0]              mem_wr_data,
  output logic                         wreg_wr_en,
  output logic      [7:0]              wreg_wr_data,
  output logic                         jump_en,
  output logic      [19:0]             jump_target,
  output logic      [7:0]              alu_condition_flags,
  output logic      [11:0]             pointer_pair_0,
  output logic      [11:0]             pointer_pair_1,
  output logic      [11:0]             pointer_pair_2
);

  import core_addr_pkg::*;

  // ==========================================================
  // decoding shared by read and write paths
  function automatic logic [11:0] direct_address(
    input logic [7:0]  f,
    input logic        acc,
    input logic [3:0]  bank,
    input logic        ext,
    input logic [11:0] idx_base
  );
    if (acc)
      return {bank, f};
    else if (ext && f <= INDEXED_LIMIT)
      return idx_base + {4'h0, f};
    else if (f < ACCESS_SPLIT)
      return {4'h0, f};
    else
      return {ACCESS_HIGH_BANK, f};
  endfunction

  // {hit, pair, kind}; a pair's operands sit at and just below its base
  function automatic logic [5:0] virt_decode(input logic [11:0] a);
    logic [11:0] d;
    virt_decode = '0;
    for (int i = 0; i < 3; i++) begin
      d = VIRT_BASE[i] - a;
      if (d <= {9'h000, VIRT_ADD_W})
        virt_decode = {1'b1, 2'(i), d[2:0]};
    end
  endfunction

  // ==========================================================
  // state and internal signals
  logic [4:0]  flags;
  logic [11:0] ptr [3];
  logic [11:0] direct_addr;
  logic [5:0]  virt;
  logic [5:0]  virt_inner;
  logic        virt_hit;
  logic [1:0]  virt_pair;
  logic [2:0]  virt_kind;
  logic [11:0] sel_ptr;
  logic [11:0] eff_addr;
  logic        ind_to_virt;
  logic        uses_file;
  logic        byte_op;
  logic        to_file;
  logic        to_wreg;
  logic [11:0] wr_addr;
  logic [7:0]  opnd_f;
  logic [7:0]  result;
  logic [4:0]  flag_mask;
  logic [4:0]  flag_val;
  logic        flag_dest;
  logic        own_dest;
  logic        step_inc;
  logic        step_dec;

  assign alu_condition_flags = {3'b000, flags};
  assign pointer_pair_0      = ptr[0];
  assign pointer_pair_1      = ptr[1];
  assign pointer_pair_2      = ptr[2];

  // ==========================================================
  // address generation
  always_comb begin
    byte_op   = op_kind inside {op_add_reg, op_sub_reg, op_and, op_or,
                                op_xor, op_rot_left, op_rot_right, op_swap};
    uses_file = byte_op || op_kind inside {op_clr, op_bit_set, op_bit_clr,
                                           op_move_w};
    direct_addr = direct_address(file_addr, access_sel, bank_select_reg,
                                 extended_isa_enable, ptr[2]);
    virt      = virt_decode(direct_addr);
    virt_hit  = uses_file && virt[5];
    virt_pair = virt[4:3];
    virt_kind = virt[2:0];
    sel_ptr   = ptr[virt_pair];
    unique case (virt_kind)
      VIRT_INC_USE: eff_addr = sel_ptr + 12'h001;
      VIRT_ADD_W:   eff_addr = sel_ptr + {{4{wreg[7]}}, wreg};
      default:     eff_addr = sel_ptr;
    endcase
    if (!virt_hit)
      eff_addr = direct_addr;
    // pointing one virtual operand at another reads zero, writes no file register
    virt_inner  = virt_decode(eff_addr);
    ind_to_virt = virt_hit && virt_inner[5];
    mem_rd_addr = (op_kind == op_move_ff) ? long_src : eff_addr;
    wr_addr     = (op_kind == op_move_ff) ? long_dst : eff_addr;
  end

  // ==========================================================
  // source operand: own registers answer, zero through a pointer at a virtual operand, memory for the rest
  always_comb begin
    opnd_f = file_rdata;
    if (mem_rd_addr == FLAGS_ADDR)
      opnd_f = {3'b000, flags};
    for (int i = 0; i < 3; i++) begin
      if (mem_rd_addr == PTR_LOW[i])
        opnd_f = ptr[i][7:0];
      if (mem_rd_addr == PTR_HIGH[i])
        opnd_f = {4'h0, ptr[i][11:8]};
    end
    if (ind_to_virt)
      opnd_f = 8'h00;
  end

  alu_flag_unit u_alu (
    .op        (op_kind),
    .opnd_f    (opnd_f),
    .opnd_w    (wreg),
    .literal   (literal),
    .bit_sel   (bit_sel),
    .carry_in  (flags[FLAG_CARRY]),
    .result    (result),
    .flag_mask (flag_mask),
    .flag_val  (flag_val)
  );

  // ==========================================================
  // destination choice
  always_comb begin
    to_file = op_valid && !ind_to_virt &&
              ((byte_op && dest_sel) ||
               op_kind inside {op_clr, op_bit_set, op_bit_clr, op_move_w,
                               op_move_ff});
    to_wreg = op_valid && ((byte_op && !dest_sel) ||
              op_kind inside {op_add_lit, op_sub_lit});
    flag_dest = to_file && wr_addr == FLAGS_ADDR;
    own_dest  = flag_dest;
    for (int i = 0; i < 3; i++)
      if (wr_addr == PTR_LOW[i] || wr_addr == PTR_HIGH[i])
        own_dest = own_dest || to_file;
    step_inc = op_valid && virt_hit &&
               (virt_kind == VIRT_USE_INC || virt_kind == VIRT_INC_USE);
    step_dec = op_valid && virt_hit && virt_kind == VIRT_USE_DEC;
  end

  // ==========================================================
  // condition flags
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      flags <= FLAGS_RESET;
    end else if (op_valid) begin
      if (flag_dest && flag_mask == 5'h00)
        flags <= result[4:0];
      else
        flags <= (flags & ~flag_mask) | (flag_val & flag_mask);
    end
  end

  // ==========================================================
  // pointer pairs
  for (genvar g = 0; g < 3; g++) begin : g_ptr
    pointer_pair u_pair (
      .core_clk (core_clk),
      .nrst     (nrst),
      .wr_low   (to_file && wr_addr == PTR_LOW[g]),
      .wr_high  (to_file && wr_addr == PTR_HIGH[g]),
      .wr_data  (result),
      .step_inc (step_inc && virt_pair == 2'(g)),
      .step_dec (step_dec && virt_pair == 2'(g)),
      .ptr      (ptr[g])
    );
  end

  // ==========================================================
  // registered write and jump outputs
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      mem_wr_en   <= 1'b0;
      mem_wr_addr <= 12'h000;
      mem_wr_data <= 8'h00;
    end else begin
      mem_wr_en   <= to_file && !own_dest;
      mem_wr_addr <= wr_addr;
      mem_wr_data <= result;
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      wreg_wr_en   <= 1'b0;
      wreg_wr_data <= 8'h00;
    end else begin
      wreg_wr_en   <= to_wreg;
      wreg_wr_data <= result;
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      jump_en     <= 1'b0;
      jump_target <= 20'h0_0000;
    end else begin
      jump_en <= op_valid && op_kind == op_jump;
      if (op_valid && op_kind == op_jump)
        jump_target <= jump_addr;
    end
  end

  // ==========================================================
  // checks
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!nrst);

  flag_dest_drop_a: assert property (
    op_valid && flag_dest && flag_mask != 5'h00 |=> !mem_wr_en &&
    flags == (($past(flags) & ~$past(flag_mask)) |
              ($past(flag_val) & $past(flag_mask))))
    else $error("flag destination result not discarded");
  upper_bits_zero_a: assert property (
    alu_condition_flags[7:5] == 3'b000)
    else $error("unimplemented flag bits not zero");
  negative_flag_a: assert property (
    op_valid && flag_mask[FLAG_NEG] |=>
    flags[FLAG_NEG] == $past(result[7]))
    else $error("negative flag wrong");
  zero_flag_a: assert property (
    op_valid && flag_mask[FLAG_ZERO] |=>
    flags[FLAG_ZERO] == ($past(result) == 8'h00))
    else $error("zero flag wrong");
  sub_borrow_a: assert property (
    op_valid && op_kind == op_sub_reg |=>
    flags[FLAG_CARRY] == ($past(opnd_f) >= $past(wreg)))
    else $error("carry is not inverted borrow");
  rot_carry_a: assert property (
    op_valid && op_kind == op_rot_left |=>
    flags[FLAG_CARRY] == $past(opnd_f[7]) &&
    flags[FLAG_NIB] == $past(opnd_f[3]))
    else $error("rotate carry load wrong");
  banked_addr_a: assert property (
    op_valid && uses_file && access_sel && !virt_hit |->
    mem_rd_addr == {bank_select_reg, file_addr})
    else $error("banked address wrong");
  access_bank_a: assert property (
    op_valid && uses_file && !access_sel && !extended_isa_enable &&
    !virt_hit |->
    mem_rd_addr[7:0] == file_addr &&
    mem_rd_addr[11:8] == (file_addr[7] ? 4'hF : 4'h0))
    else $error("access bank address wrong");
  indirect_addr_a: assert property (
    op_valid && virt_hit && virt_kind == VIRT_PLAIN |->
    mem_rd_addr == ptr[virt_pair])
    else $error("indirect address not the pointer");
  post_inc_a: assert property (
    op_valid && virt_hit && virt_kind == VIRT_USE_INC && !own_dest |=>
    ptr[$past(virt_pair)] == $past(sel_ptr) + 12'h001)
    else $error("pointer step wrong");
  dest_wreg_a: assert property (
    op_valid && byte_op && !dest_sel |=> wreg_wr_en && !mem_wr_en)
    else $error("destination bit ignored");
  jump_target_a: assert property (
    op_valid && op_kind == op_jump |=> jump_en &&
    jump_target == $past(jump_addr))
    else $error("jump target not carried");

  add_cover_c:      cover property (op_valid && op_kind == op_add_reg);
  ptr_offset_cover_c: cover property (op_valid && virt_hit &&
                                      virt_kind == VIRT_ADD_W);
  flag_dest_cover_c: cover property (op_valid && flag_dest);
  indexed_cover_c:  cover property (op_valid && uses_file &&
                                    extended_isa_enable && !access_sel &&
                                    file_addr <= INDEXED_LIMIT);

endmodule // core_status_addr

// [hdl/pointer_pair.sv]
// one 12-bit data memory pointer built from a high and low byte
`timescale 1ns/100ps
module pointer_pair
  import core_addr_pkg::*;
(
  input  wire logic        core_clk,
  input  wire logic        nrst,
  input  wire logic        wr_low,
  input  wire logic        wr_high,
  input  wire logic [7:0]  wr_data,
  input  wire logic        step_inc,
  input  wire logic        step_dec,
  output logic      [11:0] ptr
);

  // direct writes win over a pending step; steps never touch flags
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      ptr <= PTR_RESET;
    end else if (wr_low || wr_high) begin
      if (wr_low)  ptr[7:0]  <= wr_data;
      if (wr_high) ptr[11:8] <= wr_data[3:0];
    end else if (step_inc) begin
      ptr <= ptr + 12'h001;
    end else if (step_dec) begin
      ptr <= ptr - 12'h001;
    end
  end

endmodule // pointer_pair
